/* design/amp_ctrl_regs.sv */
// Control register bank of the class-D amplifier with soft mute ramps and page walk
//
// Function
// - Module reset pulses reset of interpolation filter, DAC and DSP, clearing coefficient RAM.
// - Module reset clears itself; accepted only while the device sits in high impedance.
// - Register reset restores all mode registers to reset values; RAM is untouched.
// - Switching-frequency field picks 768kHz, 384kHz or 1.024MHz; other codes reserved.
// - Output configuration bit selects stereo bridge load or mono parallel bridge.
// - Modulation field picks two-level, single-sided or hybrid; code 11 reserved.
// - DSP hold bit resets to one; clearing it starts the DSP, and audio output in play state.
// - Left mute bit ramps channel 1 volume smoothly down, clearing ramps it up.
// - Right mute bit ramps channel 2 volume smoothly down, clearing ramps it up.
// - Power state field selects deep sleep, sleep, high impedance or play.
// - Wrap enabled: page end in non-zero book continues at offset 8 of next page.
// - Wrap disabled: page end returns to offset 0 of the same page.
`timescale 1ns/1ps
`default_nettype none

module amp_ctrl_regs
  import amp_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire amp_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic [7:0] load_detect_result_in,
  input wire logic seq_step,
  input wire logic [7:0] acc_book,
  input wire logic [7:0] acc_page,
  input wire logic [6:0] acc_offset,
  output logic [7:0] walk_page,
  output logic [6:0] walk_offset,
  output amp_ctrl_t ctrl,
  output logic module_reset,
  output logic dsp_reset,
  output logic audio_run,
  output logic [7:0] gain_l,
  output logic [7:0] gain_r
);

  // ************************************************************
  // Decode helpers
  // ************************************************************
  function automatic logic fsw_ok(input logic [2:0] code);
    fsw_ok = (code == AMP_FSW_768K) || (code == AMP_FSW_384K) || (code == AMP_FSW_1024K);
  endfunction : fsw_ok

  function automatic logic wr_hit(input amp_reg_req_t req, input logic [7:0] ofs);
    wr_hit = req.wr && (req.addr == ofs);
  endfunction : wr_hit

  // ************************************************************
  // Register state
  // ************************************************************
  logic [2:0] fsw_q;
  logic mono_parallel_bridge_load_q;
  logic [1:0] modul_q;
  logic [7:0] ctrl2_q;
  logic page_dis_q;
  logic [7:0] ld_old_q;
  logic [7:0] ld_sld_a_q;
  logic [7:0] ld_sld_b_q;
  logic [7:0] ramp_cnt;
  logic ramp_tick;
  logic [7:0] gain [2];

  wire wr_reset = wr_hit(reg_req, AMP_OFS_RESET);
  wire wr_ctrl1 = wr_hit(reg_req, AMP_OFS_CTRL1);
  wire wr_ctrl2 = wr_hit(reg_req, AMP_OFS_CTRL2);
  wire wr_page = wr_hit(reg_req, AMP_OFS_PAGE);
  wire reg_reset_req = wr_reset && reg_req.wdata[AMP_BIT_REG_RST];
  wire in_hiz = (ctrl2_q[AMP_STATE_LSB +: 2] == AMP_ST_HIZ);
  wire mod_reset_req = wr_reset && reg_req.wdata[AMP_BIT_MOD_RST] && in_hiz;
  wire [2:0] fsw_wr = reg_req.wdata[AMP_FSW_LSB +: 3];
  wire [1:0] modul_wr = reg_req.wdata[AMP_MODUL_LSB +: 2];
  wire modul_ok = (modul_wr != 2'b11);

  // ************************************************************
  // Mode registers
  // ************************************************************
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fsw_q <= AMP_RST_CTRL1[AMP_FSW_LSB +: 3];
      mono_parallel_bridge_load_q <= AMP_RST_CTRL1[AMP_BIT_MONO_PARALLEL_BRIDGE_LOAD];
      modul_q <= AMP_RST_CTRL1[AMP_MODUL_LSB +: 2];
      ctrl2_q <= AMP_RST_CTRL2;
      page_dis_q <= AMP_RST_PAGE[AMP_BIT_PAGE_INC_DIS];
      ld_old_q <= AMP_RST_LD;
      ld_sld_a_q <= AMP_RST_LD;
      ld_sld_b_q <= AMP_RST_LD;
    end
    else if (reg_reset_req)
    begin
      fsw_q <= AMP_RST_CTRL1[AMP_FSW_LSB +: 3];
      mono_parallel_bridge_load_q <= AMP_RST_CTRL1[AMP_BIT_MONO_PARALLEL_BRIDGE_LOAD];
      modul_q <= AMP_RST_CTRL1[AMP_MODUL_LSB +: 2];
      ctrl2_q <= AMP_RST_CTRL2;
      page_dis_q <= AMP_RST_PAGE[AMP_BIT_PAGE_INC_DIS];
      ld_old_q <= AMP_RST_LD;
      ld_sld_a_q <= AMP_RST_LD;
      ld_sld_b_q <= AMP_RST_LD;
    end
    else
    begin
      if (wr_ctrl1 && fsw_ok(fsw_wr))
        fsw_q <= fsw_wr;
      if (wr_ctrl1)
        mono_parallel_bridge_load_q <= reg_req.wdata[AMP_BIT_MONO_PARALLEL_BRIDGE_LOAD];
      if (wr_ctrl1 && modul_ok)
        modul_q <= modul_wr;
      if (wr_ctrl2)
        ctrl2_q <= {3'b000, reg_req.wdata[4:0]};
      if (wr_page)
        page_dis_q <= reg_req.wdata[AMP_BIT_PAGE_INC_DIS];
      if (wr_hit(reg_req, AMP_OFS_OLD))
        ld_old_q <= reg_req.wdata;
      if (wr_hit(reg_req, AMP_OFS_SLD_A))
        ld_sld_a_q <= reg_req.wdata;
      if (wr_hit(reg_req, AMP_OFS_SLD_B))
        ld_sld_b_q <= reg_req.wdata;
    end
  end

  // ************************************************************
  // Self-clearing module reset pulse
  // ************************************************************
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      module_reset <= 1'b0;
    else
      module_reset <= mod_reset_req;
  end

  // The DSP reset also clears coefficient RAM in the DSP itself
  assign dsp_reset = ctrl2_q[AMP_BIT_DSP_RST] | module_reset;
  assign audio_run = !dsp_reset && (ctrl2_q[AMP_STATE_LSB +: 2] == AMP_ST_PLAY);

  assign ctrl.fsw = amp_fsw_t'(fsw_q);
  assign ctrl.parallel_bridge_select = mono_parallel_bridge_load_q;
  assign ctrl.modulation = amp_mod_t'(modul_q);
  assign ctrl.dsp_hold = ctrl2_q[AMP_BIT_DSP_RST];
  assign ctrl.left_soft_mute = ctrl2_q[AMP_BIT_MUTE_L];
  assign ctrl.right_soft_mute = ctrl2_q[AMP_BIT_MUTE_R];
  assign ctrl.power_state_select = amp_pstate_t'(ctrl2_q[AMP_STATE_LSB +: 2]);

  // ************************************************************
  // Read port
  // ************************************************************
  logic [7:0] rd_mux;

  always_comb
  begin
    case (reg_req.addr)
      AMP_OFS_CTRL1: rd_mux = {1'b0, fsw_q, 1'b0, mono_parallel_bridge_load_q, modul_q};
      AMP_OFS_CTRL2: rd_mux = ctrl2_q;
      AMP_OFS_PAGE: rd_mux = {4'h0, page_dis_q, 3'b000};
      AMP_OFS_OLD: rd_mux = ld_old_q;
      AMP_OFS_SLD_A: rd_mux = ld_sld_a_q;
      AMP_OFS_SLD_B: rd_mux = ld_sld_b_q;
      AMP_OFS_LOAD_DETECT_RESULT: rd_mux = load_detect_result_in;
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_req.rd;
      if (reg_req.rd)
        reg_rdata <= rd_mux;
    end
  end

  // ************************************************************
  // Soft mute ramps
  // ************************************************************
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      ramp_cnt <= 8'h00;
    else if (ramp_tick)
      ramp_cnt <= 8'h00;
    else
      ramp_cnt <= ramp_cnt + 8'h01;
  end

  assign ramp_tick = (ramp_cnt == 8'(AMP_RAMP_CYCLES - 1));

  wire [1:0] mute_req = {ctrl2_q[AMP_BIT_MUTE_R], ctrl2_q[AMP_BIT_MUTE_L]};

  for (genvar ch = 0; ch < 2; ch++)
  begin : g_ramp
    always_ff @(posedge mclk or negedge arst_n)
    begin
      if (!arst_n)
        gain[ch] <= AMP_GAIN_FULL;
      else if (ramp_tick && mute_req[ch] && gain[ch] != AMP_GAIN_ZERO)
        gain[ch] <= gain[ch] - 8'h01;
      else if (ramp_tick && !mute_req[ch] && gain[ch] != AMP_GAIN_FULL)
        gain[ch] <= gain[ch] + 8'h01;
    end
  end

  assign gain_l = gain[0];
  assign gain_r = gain[1];

  // ************************************************************
  // Page auto-increment walk
  // ************************************************************
  wire at_end = (acc_offset == AMP_PAGE_LAST);
  wire go_next = at_end && !page_dis_q && (acc_book != 8'h00);

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      walk_page <= 8'h00;
      walk_offset <= 7'h00;
    end
    else if (seq_step)
    begin
      if (go_next)
      begin
        walk_page <= acc_page + 8'h01;
        walk_offset <= AMP_PAGE_RESTART;
      end
      else if (at_end)
      begin
        walk_page <= acc_page;
        walk_offset <= AMP_PAGE_FIRST;
      end
      else
      begin
        walk_page <= acc_page;
        walk_offset <= acc_offset + 7'h01;
      end
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  property p_modrst_hiz;
    @(posedge mclk) disable iff (!arst_n)
    module_reset |-> $past(in_hiz);
  endproperty
  a_modrst_hiz: assert property (p_modrst_hiz) else $error("module reset outside hi-z");

  property p_modrst_pulse;
    @(posedge mclk) disable iff (!arst_n)
    (wr_reset && reg_req.wdata[AMP_BIT_MOD_RST] && in_hiz) |=> module_reset && dsp_reset;
  endproperty
  a_modrst_pulse: assert property (p_modrst_pulse) else $error("module reset missed");

  property p_modrst_clear;
    @(posedge mclk) disable iff (!arst_n)
    (module_reset && !mod_reset_req) |=> !module_reset;
  endproperty
  a_modrst_clear: assert property (p_modrst_clear) else $error("module reset stuck");

  property p_regrst;
    @(posedge mclk) disable iff (!arst_n)
    reg_reset_req |=> (ctrl2_q == AMP_RST_CTRL2) && (fsw_q == 3'b000) && !page_dis_q;
  endproperty
  a_regrst: assert property (p_regrst) else $error("register reset incomplete");

  property p_fsw_hold;
    @(posedge mclk) disable iff (!arst_n)
    (wr_ctrl1 && !fsw_ok(fsw_wr) && !reg_reset_req) |=> (fsw_q == $past(fsw_q));
  endproperty
  a_fsw_hold: assert property (p_fsw_hold) else $error("reserved frequency taken");

  property p_mod_valid;
    @(posedge mclk) disable iff (!arst_n)
    (modul_q != 2'b11) && fsw_ok(fsw_q);
  endproperty
  a_mod_valid: assert property (p_mod_valid) else $error("reserved mode active");

  property p_run;
    @(posedge mclk) disable iff (!arst_n)
    audio_run |-> !ctrl2_q[AMP_BIT_DSP_RST] && ctrl.power_state_select == AMP_ST_PLAY;
  endproperty
  a_run: assert property (p_run) else $error("audio runs while held");

  property p_mute_down;
    @(posedge mclk) disable iff (!arst_n)
    (ramp_tick && mute_req[0] && !reg_reset_req && !wr_ctrl2 && gain_l != 8'h00)
      |=> gain_l == $past(gain_l) - 8'h01;
  endproperty
  a_mute_down: assert property (p_mute_down) else $error("left ramp wrong");

  property p_unmute_up;
    @(posedge mclk) disable iff (!arst_n)
    (ramp_tick && !mute_req[1] && gain_r != 8'hFF) |=> gain_r == $past(gain_r) + 8'h01;
  endproperty
  a_unmute_up: assert property (p_unmute_up) else $error("right ramp wrong");

  property p_walk_next;
    @(posedge mclk) disable iff (!arst_n)
    (seq_step && go_next) |=> walk_offset == 7'h08 && walk_page == $past(acc_page) + 8'h01;
  endproperty
  a_walk_next: assert property (p_walk_next) else $error("page advance wrong");

  property p_walk_wrap;
    @(posedge mclk) disable iff (!arst_n)
    (seq_step && at_end && page_dis_q) |=> walk_offset == 7'h00 && walk_page == $past(acc_page);
  endproperty
  a_walk_wrap: assert property (p_walk_wrap) else $error("page wrap wrong");

  property p_modul_hold;
    @(posedge mclk) disable iff (!arst_n)
    (wr_ctrl1 && !modul_ok && !reg_reset_req) |=> (modul_q == $past(modul_q));
  endproperty
  a_modul_hold: assert property (p_modul_hold) else $error("reserved modulation taken");

  property p_mono_parallel_bridge_load_write;
    @(posedge mclk) disable iff (!arst_n)
    (wr_ctrl1 && !reg_reset_req)
      |=> ctrl.parallel_bridge_select == $past(reg_req.wdata[AMP_BIT_MONO_PARALLEL_BRIDGE_LOAD]);
  endproperty
  a_mono_parallel_bridge_load_write: assert property (p_mono_parallel_bridge_load_write) else $error("bridge select not written");

  property p_gain_still;
    @(posedge mclk) disable iff (!arst_n)
    !ramp_tick |=> $stable(gain_l) && $stable(gain_r);
  endproperty
  a_gain_still: assert property (p_gain_still) else $error("gain moved between ticks");

  property p_regrst_hold;
    @(posedge mclk) disable iff (!arst_n)
    reg_reset_req |=> dsp_reset && !audio_run;
  endproperty
  a_regrst_hold: assert property (p_regrst_hold) else $error("DSP free after register reset");

endmodule : amp_ctrl_regs

`default_nettype wire

/* design/amp_pkg.sv */
// Package for the amplifier control register bank: offsets, fields, resets, types
package amp_pkg;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [7:0] AMP_OFS_RESET = 8'h01;
  localparam logic [7:0] AMP_OFS_CTRL1 = 8'h02;
  localparam logic [7:0] AMP_OFS_CTRL2 = 8'h03;
  localparam logic [7:0] AMP_OFS_PAGE = 8'h0F;
  localparam logic [7:0] AMP_OFS_OLD = 8'h79;
  localparam logic [7:0] AMP_OFS_SLD_A = 8'h7A;
  localparam logic [7:0] AMP_OFS_SLD_B = 8'h7B;
  localparam logic [7:0] AMP_OFS_LOAD_DETECT_RESULT = 8'h7C;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int AMP_BIT_MOD_RST = 4;
  localparam int AMP_BIT_REG_RST = 0;
  localparam int AMP_FSW_LSB = 4;
  localparam int AMP_BIT_MONO_PARALLEL_BRIDGE_LOAD = 2;
  localparam int AMP_MODUL_LSB = 0;
  localparam int AMP_BIT_DSP_RST = 4;
  localparam int AMP_BIT_MUTE_L = 3;
  localparam int AMP_BIT_MUTE_R = 2;
  localparam int AMP_STATE_LSB = 0;
  localparam int AMP_BIT_PAGE_INC_DIS = 3;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0] AMP_RST_CTRL1 = 8'h00;
  localparam logic [7:0] AMP_RST_CTRL2 = 8'h10;
  localparam logic [7:0] AMP_RST_PAGE = 8'h00;
  localparam logic [7:0] AMP_RST_LD = 8'h00;

  // ************************************************************
  // Page walk constants
  // ************************************************************
  localparam logic [6:0] AMP_PAGE_LAST = 7'h7F;
  localparam logic [6:0] AMP_PAGE_RESTART = 7'h08;
  localparam logic [6:0] AMP_PAGE_FIRST = 7'h00;

  // ************************************************************
  // Timing: soft mute ramp step
  // ************************************************************
  localparam int AMP_CLK_PERIOD_NS = 40;
  localparam int AMP_RAMP_STEP_NS = 10000;
  localparam int AMP_RAMP_CYCLES = AMP_RAMP_STEP_NS / AMP_CLK_PERIOD_NS;
  localparam logic [7:0] AMP_GAIN_FULL = 8'hFF;
  localparam logic [7:0] AMP_GAIN_ZERO = 8'h00;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [2:0] {
    AMP_FSW_768K = 3'b000,
    AMP_FSW_384K = 3'b001,
    AMP_FSW_1024K = 3'b101
  } amp_fsw_t;

  typedef enum logic [1:0] {
    AMP_MOD_TWO_LEVEL = 2'b00,
    AMP_MOD_SINGLE_SIDED = 2'b01,
    AMP_MOD_HYBRID = 2'b10
  } amp_mod_t;

  typedef enum logic [1:0] {
    AMP_ST_DEEP_SLEEP = 2'b00,
    AMP_ST_SLEEP = 2'b01,
    AMP_ST_HIZ = 2'b10,
    AMP_ST_PLAY = 2'b11
  } amp_pstate_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } amp_reg_req_t;

  typedef struct packed {
    amp_fsw_t fsw;
    logic parallel_bridge_select;
    amp_mod_t modulation;
    logic dsp_hold;
    logic left_soft_mute;
    logic right_soft_mute;
    amp_pstate_t power_state_select;
  } amp_ctrl_t;

endpackage : amp_pkg

/* test/amp_ctrl_regs_tb.sv */
// Self-checking testbench for the amplifier control register bank
`timescale 1ns/1ps
`default_nettype none

module amp_ctrl_regs_tb;
  import amp_pkg::*;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic seq_step = 1'b0;
  logic [7:0] load_detect_result_in = 8'h00;
  logic [7:0] acc_book = 8'h00;
  logic [7:0] acc_page = 8'h00;
  logic [6:0] acc_offset = 7'h00;
  amp_reg_req_t reg_req;
  amp_ctrl_t ctrl;
  logic [7:0] reg_rdata, walk_page, gain_l, gain_r, gl, gr;
  logic [6:0] walk_offset;
  logic reg_rvalid, module_reset, dsp_reset, audio_run;
  int fails = 0;
  int check_count = 0;

  always #20 mclk = ~mclk;

  amp_host_model host_u (.mclk(mclk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .reg_req(reg_req));

  amp_ctrl_regs dut_u (.mclk(mclk), .arst_n(arst_n), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .load_detect_result_in(load_detect_result_in),
    .seq_step(seq_step), .acc_book(acc_book), .acc_page(acc_page),
    .acc_offset(acc_offset), .walk_page(walk_page), .walk_offset(walk_offset),
    .ctrl(ctrl), .module_reset(module_reset), .dsp_reset(dsp_reset),
    .audio_run(audio_run), .gain_l(gain_l), .gain_r(gain_r));

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic rd_chk(input string what, input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    logic v;
    host_u.read_reg(addr, d, v);
    check({what, " valid"}, 8'h01, {7'h00, v});
    check(what, exp, d);
  endtask : rd_chk

  task automatic walk(input logic [7:0] bk, input logic dis, input logic [6:0] ofs,
    input logic [7:0] exp_pg, input logic [6:0] exp_ofs);
    host_u.write_reg(AMP_OFS_PAGE, {4'h0, dis, 3'h0});
    acc_book = bk;
    acc_page = 8'h03;
    acc_offset = ofs;
    seq_step = 1'b1;
    @(negedge mclk);
    seq_step = 1'b0;
    check("walk page", exp_pg, walk_page);
    check("walk offset", {1'b0, exp_ofs}, {1'b0, walk_offset});
  endtask : walk

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic test_reset();
    load_detect_result_in = 8'hA5;
    rd_chk("ctrl1", AMP_OFS_CTRL1, 8'h00);
    rd_chk("ctrl2", AMP_OFS_CTRL2, 8'h10);
    rd_chk("page", AMP_OFS_PAGE, 8'h00);
    rd_chk("reset reg", AMP_OFS_RESET, 8'h00);
    rd_chk("unmapped", 8'h55, 8'h00);
    rd_chk("load_detect_result", AMP_OFS_LOAD_DETECT_RESULT, 8'hA5);
    @(negedge mclk);
    check("rvalid drop", 8'h00, {7'h00, reg_rvalid});
    check("dsp_reset", 8'h01, {7'h00, dsp_reset});
    check("gain_l", AMP_GAIN_FULL, gain_l);
    $display("test_reset done");
  endtask : test_reset

  task automatic test_modes();
    logic [2:0] f;
    logic [1:0] m;
    logic [2:0] ef;
    logic [1:0] em;
    ef = 3'b000;
    em = 2'b00;
    for (int i = 0; i < 8; i++)
    begin
      f = i[2:0];
      m = i[1:0];
      if (f == 3'b000 || f == 3'b001 || f == 3'b101)
        ef = f;
      if (m != 2'b11)
        em = m;
      host_u.write_reg(AMP_OFS_CTRL1, {1'b0, f, 1'b0, i[0], m});
      rd_chk("ctrl1", AMP_OFS_CTRL1, {1'b0, ef, 1'b0, i[0], em});
      check("fsw", {5'h00, ef}, {5'h00, ctrl.fsw});
      check("mono_parallel_bridge_load", {7'h00, i[0]}, {7'h00, ctrl.parallel_bridge_select});
      check("modulation", {6'h00, em}, {6'h00, ctrl.modulation});
    end
    $display("test_modes done");
  endtask : test_modes

  task automatic test_states();
    for (int s = 0; s < 4; s++)
    begin
      host_u.write_reg(AMP_OFS_CTRL2, {6'h00, s[1:0]});
      check("state", {6'h00, s[1:0]}, {6'h00, ctrl.power_state_select});
      check("audio_run", {7'h00, s == 3}, {7'h00, audio_run});
    end
    host_u.write_reg(AMP_OFS_CTRL2, 8'h13);
    check("held run", 8'h00, {7'h00, audio_run});
    check("held reset", 8'h01, {7'h00, dsp_reset});
    check("hold flag", 8'h01, {7'h00, ctrl.dsp_hold});
    $display("test_states done");
  endtask : test_states

  task automatic test_module_reset();
    host_u.write_reg(AMP_OFS_CTRL2, 8'h03);
    host_u.write_reg(AMP_OFS_RESET, 8'h10);
    check("mod rst in play", 8'h00, {7'h00, module_reset});
    host_u.write_reg(AMP_OFS_CTRL2, 8'h02);
    host_u.write_reg(AMP_OFS_RESET, 8'h10);
    check("mod rst pulse", 8'h01, {7'h00, module_reset});
    check("dsp rst pulse", 8'h01, {7'h00, dsp_reset});
    @(negedge mclk);
    check("mod rst clear", 8'h00, {7'h00, module_reset});
    check("dsp rst clear", 8'h00, {7'h00, dsp_reset});
    $display("test_module_reset done");
  endtask : test_module_reset

  task automatic test_reg_reset();
    host_u.write_reg(AMP_OFS_CTRL1, 8'h56);
    host_u.write_reg(AMP_OFS_PAGE, 8'h08);
    host_u.write_reg(AMP_OFS_SLD_A, 8'h5A);
    rd_chk("sld a", AMP_OFS_SLD_A, 8'h5A);
    host_u.write_reg(AMP_OFS_RESET, 8'h01);
    rd_chk("sld a cleared", AMP_OFS_SLD_A, 8'h00);
    rd_chk("ctrl1 cleared", AMP_OFS_CTRL1, 8'h00);
    rd_chk("ctrl2 cleared", AMP_OFS_CTRL2, 8'h10);
    rd_chk("page cleared", AMP_OFS_PAGE, 8'h00);
    $display("test_reg_reset done");
  endtask : test_reg_reset

  task automatic test_walk();
    walk(8'h01, 1'b0, 7'h7F, 8'h04, 7'h08);
    walk(8'h01, 1'b1, 7'h7F, 8'h03, 7'h00);
    walk(8'h02, 1'b0, 7'h10, 8'h03, 7'h11);
    $display("test_walk done");
  endtask : test_walk

  task automatic test_mute();
    host_u.write_reg(AMP_OFS_CTRL2, 8'h0F);
    check("mute flags", 8'h03, {6'h00, ctrl.left_soft_mute, ctrl.right_soft_mute});
    repeat (500) @(negedge mclk);
    check("left down", AMP_GAIN_FULL - 8'h02, gain_l);
    check("right down", AMP_GAIN_FULL - 8'h02, gain_r);
    host_u.write_reg(AMP_OFS_CTRL2, 8'h07);
    gl = gain_l;
    gr = gain_r;
    repeat (500) @(negedge mclk);
    check("left up", gl + 8'h02, gain_l);
    check("right down more", gr - 8'h02, gain_r);
    $display("test_mute done");
  endtask : test_mute

  initial
  begin
    repeat (8) @(negedge mclk);
    arst_n = 1'b1;
    test_reset();
    test_modes();
    test_states();
    test_module_reset();
    test_reg_reset();
    test_walk();
    test_mute();
    complete_run();
  end

  initial
  begin
    #4000000;
    fails++;
    complete_run();
  end
endmodule : amp_ctrl_regs_tb
`default_nettype wire

/* test/amp_host_model.sv */
// Host model that issues register writes and reads to the control bank
`timescale 1ns/1ps
`default_nettype none

module amp_host_model
  import amp_pkg::*;
(
  input wire logic mclk,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  output var amp_reg_req_t reg_req
);
  initial reg_req = '{wr: 1'b0, rd: 1'b0, addr: 8'h00, wdata: 8'h00};

  // Released address and data show the inverse of the last value
  task automatic release_bus();
    @(negedge mclk);
    reg_req.wr = 1'b0;
    reg_req.rd = 1'b0;
    reg_req.addr = ~reg_req.addr;
    reg_req.wdata = ~reg_req.wdata;
  endtask : release_bus

  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(negedge mclk);
    reg_req.addr = addr;
    reg_req.wdata = data;
    reg_req.wr = 1'b1;
    release_bus();
  endtask : write_reg

  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic vld);
    @(negedge mclk);
    reg_req.addr = addr;
    reg_req.rd = 1'b1;
    release_bus();
    data = reg_rdata;
    vld = reg_rvalid;
  endtask : read_reg
endmodule : amp_host_model
`default_nettype wire
